// [rscp_port.sv]
/*
 * serial command port of an fsk transceiver with its event and request
 * logic, plus an AXI4-Lite window for the radio core side.
 * assumes the serial pins are asynchronous to aclk and slower than aclk/4.
 */
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module rscp_port import rscp_pkg::*; #(
	parameter int POR_CYCLES = POR_CYCLES_DEF,
	parameter int RX_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clk,
	input wire logic port_select_n,
	input wire logic serial_cmd_in,
	output logic serial_status_out,
	output logic serial_status_oe_n,
	output logic host_attention_n,
	input wire logic ext_event_in_n,
	output logic valid_data_flag,
	output logic valid_data_oe_n
);
	localparam int PW = $clog2(RX_DEPTH);
	localparam int CW = $clog2(POR_CYCLES + 1);

	initial begin
		if (RX_DEPTH < 2 || (1 << PW) != RX_DEPTH)
			$error("RX_DEPTH must be a power of two, at least 2");
		if (POR_CYCLES < 1 || CW > 30)
			$error("POR_CYCLES out of range");
	end

	function automatic logic hit(input logic [15:0] w,
		input logic [15:0] code, input logic [15:0] mask);
		hit = (w & mask) == code;
	endfunction : hit

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sck_s1, sck_s2, sck_s3;
	logic sel_s1, sel_s2, sel_s3;
	logic sdi_s1, sdi_s2;
	logic ext_s1, ext_s2, ext_s3;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sel_s1 <= 1'b1;
			sel_s2 <= 1'b1;
			sel_s3 <= 1'b1;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_s3 <= 1'b1;
		end else begin
			sck_s1 <= serial_clk;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sel_s1 <= port_select_n;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
			sdi_s1 <= serial_cmd_in;
			sdi_s2 <= sdi_s1;
			ext_s1 <= ext_event_in_n;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	logic sck_rise, sck_fall, frame_end;
	assign sck_rise = sck_s2 && !sck_s3 && !sel_s2;
	assign sck_fall = !sck_s2 && sck_s3 && !sel_s2;
	assign frame_end = sel_s2 && !sel_s3;

	// ------------------------------------------------------------
	// power-on timeout
	// ------------------------------------------------------------
	logic [CW-1:0] por_cnt_reg;
	logic por_busy;
	assign por_busy = por_cnt_reg != '0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			por_cnt_reg <= CW'(POR_CYCLES);
		else if (por_busy)
			por_cnt_reg <= por_cnt_reg - 1'b1;
	end

	// ------------------------------------------------------------
	// serial receiver and transmitter
	// ------------------------------------------------------------
	rscp_phase_e phase_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] shift_reg, shift_next, out_shift_reg;
	logic out_bit_reg;
	logic [7:0] snap_reg, flags_reg;
	logic [7:0] fifo_head;
	logic fifo_empty, cmd_strobe, fifo_pop;
	logic [15:0] status_word;

	assign shift_next = {shift_reg[14:0], sdi_s2};
	assign cmd_strobe = sck_rise && bit_cnt_reg == 5'h0f
		&& phase_reg == PH_CMD;
	assign fifo_pop = sck_rise && bit_cnt_reg == 5'h07
		&& phase_reg == PH_CMD && shift_next[7:0] == C_FRD
		&& !fifo_empty;
	// source of the request is visible here, on the serial status and in the A_STATUS read
	assign status_word = {flags_reg, fifo_empty, valid_data_flag,
		6'h00};

	always_ff @(posedge aclk) begin
		if (!aresetn || sel_s2) begin
			phase_reg <= PH_CMD;
			bit_cnt_reg <= 5'h00;
			shift_reg <= 16'h0000;
		end else if (sck_rise) begin
			shift_reg <= shift_next;
			if (bit_cnt_reg != 5'h1f)
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			if (bit_cnt_reg == 5'h00) begin
				if (por_busy)
					phase_reg <= PH_IGNORE;
				else if (!sdi_s2)
					phase_reg <= PH_STATUS;
			end else if (bit_cnt_reg == 5'h07 && phase_reg == PH_CMD
				&& shift_next[7:0] == C_FRD) begin
				phase_reg <= PH_FIFO;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_shift_reg <= 16'h0000;
			out_bit_reg <= 1'b0;
			snap_reg <= 8'h00;
		end else if (sel_s2) begin
			out_bit_reg <= 1'b0;
		end else if (sck_rise && bit_cnt_reg == 5'h00 && !por_busy
			&& !sdi_s2) begin
			out_shift_reg <= status_word;
			snap_reg <= flags_reg;
		end else if (fifo_pop) begin
			out_shift_reg <= {fifo_head, 8'h00};
		end else if (sck_fall && (phase_reg == PH_STATUS
			|| phase_reg == PH_FIFO)) begin
			out_bit_reg <= out_shift_reg[15];
			out_shift_reg <= {out_shift_reg[14:0], 1'b0};
		end
	end

	assign serial_status_out = out_bit_reg;
	assign serial_status_oe_n = sel_s2;

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------
	logic [15:0] cfg_reg, pwr_reg, freq_reg, rate_reg;
	logic [15:0] rxc_reg, fifo_reg, duty_reg, txc_reg;
	logic [7:0] tx_byte_value;
	logic tx_full_reg;
	logic tx_data_reg_enable, rx_fifo_enable, shared_pin_select;
	logic [3:0] fifo_fill_level;
	logic [11:0] carrier_freq_word;

	assign tx_data_reg_enable = cfg_reg[EL_BIT];
	assign rx_fifo_enable = cfg_reg[EF_BIT];
	assign shared_pin_select = rxc_reg[PSEL_BIT];
	assign fifo_fill_level = fifo_reg[FLVL_LSB +: 4];
	assign carrier_freq_word = freq_reg[11:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= CFG_POR;
			pwr_reg <= PWR_POR;
			rate_reg <= RATE_POR;
			rxc_reg <= RXC_POR;
			fifo_reg <= FIFO_POR;
			duty_reg <= DUTY_POR;
			txc_reg <= TXC_POR;
		end else if (cmd_strobe) begin
			// every field bit stored as sent: one on, zero off
			if (hit(shift_next, C_CFG, M_BYTE))
				cfg_reg <= shift_next;
			if (hit(shift_next, C_PWR, M_BYTE))
				pwr_reg <= shift_next;
			if (hit(shift_next, C_RATE, M_BYTE))
				rate_reg <= shift_next;
			if (hit(shift_next, C_RXC, M_FIVE))
				rxc_reg <= shift_next;
			if (hit(shift_next, C_FIFO, M_BYTE))
				fifo_reg <= shift_next;
			if (hit(shift_next, C_DUTY, M_BYTE))
				duty_reg <= shift_next;
			if (hit(shift_next, C_TXC, M_FIVE))
				txc_reg <= shift_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			freq_reg <= FREQ_POR;
		else if (cmd_strobe && hit(shift_next, C_FREQ, M_NIB)
			&& shift_next[11:0] >= FREQ_MIN
			&& shift_next[11:0] <= FREQ_MAX)
			freq_reg <= shift_next;
	end

	logic [3:0] ev_pulse;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_byte_value <= 8'h00;
			tx_full_reg <= 1'b0;
		end else if (cmd_strobe && hit(shift_next, C_TXW, M_BYTE)) begin
			tx_byte_value <= shift_next[7:0];
			tx_full_reg <= 1'b1;
		end else if (ev_pulse[EV_TX_TAKEN]) begin
			tx_full_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// receive fifo
	// ------------------------------------------------------------
	logic [7:0] fifo_mem [RX_DEPTH];
	logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push_req, push, fifo_full;
	logic [7:0] push_data;

	assign fifo_empty = count_reg == '0;
	assign fifo_full = count_reg == (PW+1)'(RX_DEPTH);
	assign push = push_req && rx_fifo_enable && fifo_reg[FFILL_BIT]
		&& !fifo_full;
	assign fifo_head = fifo_mem[rd_ptr_reg];

	always_ff @(posedge aclk) begin
		if (push)
			fifo_mem[wr_ptr_reg] <= push_data;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !rx_fifo_enable) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (fifo_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !fifo_pop)
				count_reg <= count_reg + 1'b1;
			else if (fifo_pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// event flags and request line
	// ------------------------------------------------------------
	logic [7:0] set_vec, clr_vec;
	logic [PW+3:0] fill_bits;

	assign fill_bits = {count_reg + 1'b1, 3'b000};

	always_comb begin
		set_vec = 8'h00;
		set_vec[F_TXRDY] = tx_data_reg_enable
			&& ev_pulse[EV_TX_TAKEN];
		set_vec[F_UNDR] = tx_data_reg_enable
			&& ev_pulse[EV_UNDERRUN];
		set_vec[F_FLVL] = rx_fifo_enable && push
			&& fill_bits >= (PW+4)'(fifo_fill_level);
		set_vec[F_OVR] = rx_fifo_enable && push_req
			&& fifo_full;
		set_vec[F_WAKE] = ev_pulse[EV_WAKE];
		set_vec[F_LOWS] = ev_pulse[EV_LOWSUP];
		set_vec[F_EXT] = !shared_pin_select && !ext_s2
			&& ext_s3;
	end

	assign clr_vec = (frame_end && phase_reg == PH_STATUS)
		? snap_reg : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			flags_reg <= 8'h20;
		else
			flags_reg <= (flags_reg & ~clr_vec) | set_vec;
	end

	assign host_attention_n = !(|flags_reg);

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic wr_go, ar_go, bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] ctrl_reg;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign ar_go = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = ar_go;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign ev_pulse = (wr_go && s_axi_awaddr == A_EVENT
		&& s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0;
	assign push_req = wr_go && s_axi_awaddr == A_RXPUSH
		&& s_axi_wstrb[0];
	assign push_data = s_axi_wdata[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OK;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			if (s_axi_awaddr == A_EVENT || s_axi_awaddr == A_CTRL
				|| s_axi_awaddr == A_RXPUSH)
				bresp_reg <= RESP_OK;
			else
				bresp_reg <= RESP_ERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_reg <= 8'h00;
		else if (wr_go && s_axi_awaddr == A_CTRL && s_axi_wstrb[0])
			ctrl_reg <= s_axi_wdata[7:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OK;
			rdata_reg <= 32'h00000000;
		end else if (ar_go) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OK;
			case (s_axi_araddr)
			A_STATUS: rdata_reg <= {15'h0000, por_busy,
				status_word};
			A_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
			A_CFG: rdata_reg <= {16'h0000, cfg_reg};
			A_PWR: rdata_reg <= {16'h0000, pwr_reg};
			A_FREQ: rdata_reg <= {20'h00000, carrier_freq_word};
			A_RATE: rdata_reg <= {16'h0000, rate_reg};
			A_RXC: rdata_reg <= {16'h0000, rxc_reg};
			A_FIFO: rdata_reg <= {16'h0000, fifo_reg};
			A_DUTY: rdata_reg <= {16'h0000, duty_reg};
			A_TXC: rdata_reg <= {16'h0000, txc_reg};
			A_TXB: rdata_reg <= {23'h000000, tx_full_reg,
				tx_byte_value};
			default: begin
				rdata_reg <= 32'h00000000;
				rresp_reg <= RESP_ERR;
			end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// shared pin
	// ------------------------------------------------------------
	assign valid_data_flag = ctrl_reg[0];
	assign valid_data_oe_n = !shared_pin_select;
endmodule : rscp_port

// [rscp_pkg.sv]
/*
 * constants for the radio serial control port: command codes, power-on
 * defaults, field positions, timing and the register map.
 * assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package rscp_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ = 25000;
	localparam int POR_TIME_MS = 150;
	localparam int POR_CYCLES_DEF = POR_TIME_MS * CLK_KHZ;
	// ------------------------------------------------------------
	// command codes and decode masks
	// ------------------------------------------------------------
	localparam logic [15:0] M_BYTE = 16'hff00;
	localparam logic [15:0] M_NIB = 16'hf000;
	localparam logic [15:0] M_FIVE = 16'hf800;
	localparam logic [15:0] C_CFG = 16'h8000;
	localparam logic [15:0] C_PWR = 16'h8200;
	localparam logic [15:0] C_FREQ = 16'ha000;
	localparam logic [15:0] C_RATE = 16'hc600;
	localparam logic [15:0] C_RXC = 16'h9000;
	localparam logic [15:0] C_FIFO = 16'hca00;
	localparam logic [15:0] C_DUTY = 16'hc800;
	localparam logic [15:0] C_TXC = 16'h9800;
	localparam logic [15:0] C_TXW = 16'hb800;
	localparam logic [7:0] C_FRD = 8'hb0;
	// ------------------------------------------------------------
	// power-on defaults
	// ------------------------------------------------------------
	localparam logic [15:0] CFG_POR = 16'h8008;
	localparam logic [15:0] PWR_POR = 16'h8208;
	localparam logic [15:0] FREQ_POR = 16'ha680;
	localparam logic [15:0] RATE_POR = 16'hc623;
	localparam logic [15:0] RXC_POR = 16'h9080;
	localparam logic [15:0] FIFO_POR = 16'hca80;
	localparam logic [15:0] DUTY_POR = 16'hc80e;
	localparam logic [15:0] TXC_POR = 16'h9800;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int EL_BIT = 7;
	localparam int EF_BIT = 6;
	localparam int PSEL_BIT = 10;
	localparam int FLVL_LSB = 4;
	localparam int FSTART_BIT = 2;
	localparam int FFILL_BIT = 1;
	localparam int DUTY_EN_BIT = 0;
	localparam int DUTY_LSB = 1;
	localparam logic [11:0] FREQ_MIN = 12'h060;
	localparam logic [11:0] FREQ_MAX = 12'hf3f;
	// ------------------------------------------------------------
	// event flags (index in the flag vector)
	// ------------------------------------------------------------
	localparam int F_TXRDY = 7;
	localparam int F_FLVL = 6;
	localparam int F_POR = 5;
	localparam int F_OVR = 4;
	localparam int F_UNDR = 3;
	localparam int F_WAKE = 2;
	localparam int F_EXT = 1;
	localparam int F_LOWS = 0;
	localparam int EV_TX_TAKEN = 0;
	localparam int EV_UNDERRUN = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_LOWSUP = 3;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_EVENT = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_RXPUSH = 8'h0c;
	localparam logic [7:0] A_CFG = 8'h10;
	localparam logic [7:0] A_PWR = 8'h14;
	localparam logic [7:0] A_FREQ = 8'h18;
	localparam logic [7:0] A_RATE = 8'h1c;
	localparam logic [7:0] A_RXC = 8'h20;
	localparam logic [7:0] A_FIFO = 8'h24;
	localparam logic [7:0] A_DUTY = 8'h28;
	localparam logic [7:0] A_TXC = 8'h2c;
	localparam logic [7:0] A_TXB = 8'h30;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [1:0] {PH_CMD, PH_STATUS, PH_FIFO, PH_IGNORE}
		rscp_phase_e;
endpackage : rscp_pkg

// [rscp_port_checker.sv]
/* checker on the rscp_port top ports.
 * assumes a bind into rscp_port. */
`timescale 1ns/1ns
module rscp_port_checker import rscp_pkg::*; #(
	parameter int POR_CYCLES = 20,
	parameter int RX_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic serial_clk,
	input wire logic port_select_n,
	input wire logic serial_status_out,
	input wire logic serial_status_oe_n,
	input wire logic host_attention_n,
	input wire logic ext_event_in_n,
	input wire logic valid_data_oe_n
);
	// ----
	// checks
	// ----
	logic [3:0] sel_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !port_select_n)
			sel_cnt <= 4'h0;
		else if (sel_cnt != 4'hf)
			sel_cnt <= sel_cnt + 4'h1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_oe_released: assert property (port_select_n[*4] |-> serial_status_oe_n)
		else $error("output enabled while deselected");
	a_oe_driven: assert property ((!port_select_n)[*4] |-> !serial_status_oe_n)
		else $error("output not enabled while selected");
	a_out_quiet: assert property (port_select_n[*4] |-> !serial_status_out)
		else $error("output not quiet while deselected");
	a_out_on_fall: assert property ((!port_select_n && serial_clk)[*3] |=>
		$stable(serial_status_out)) else $error("output moved in clock high");
	a_wr_refused: assert property (s_axi_awready && s_axi_awaddr != A_EVENT &&
		s_axi_awaddr != A_CTRL && s_axi_awaddr != A_RXPUSH |=>
		s_axi_bvalid && s_axi_bresp == RESP_ERR) else $error("bad write ok");
	a_rd_unmapped: assert property (s_axi_arready && s_axi_araddr > A_TXB |=>
		s_axi_rvalid && s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_lowsup_irq: assert property (s_axi_awready && s_axi_awaddr == A_EVENT &&
		s_axi_wstrb[0] && s_axi_wdata[EV_LOWSUP] |-> ##[1:3] !host_attention_n)
		else $error("low supply gave no request");
	a_ext_irq: assert property ($fell(ext_event_in_n) && valid_data_oe_n |->
		##[1:6] !host_attention_n) else $error("pin event gave no request");
	a_irq_held: assert property ($rose(host_attention_n) |-> port_select_n &&
		sel_cnt != 4'h0 && sel_cnt < 4'h9) else $error("request dropped early");
	a_por_irq: assert property ($rose(aresetn) |-> !host_attention_n)
		else $error("no request after reset");
	c_write: cover property (s_axi_awready);
	c_irq_clear: cover property ($rose(host_attention_n));
	c_pin_out: cover property ($fell(ext_event_in_n) && !valid_data_oe_n);
endmodule : rscp_port_checker

bind rscp_port rscp_port_checker #(.POR_CYCLES(POR_CYCLES),
	.RX_DEPTH(RX_DEPTH)) rscp_port_checker_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
	.serial_clk(serial_clk), .port_select_n(port_select_n),
	.serial_status_out(serial_status_out),
	.serial_status_oe_n(serial_status_oe_n),
	.host_attention_n(host_attention_n), .ext_event_in_n(ext_event_in_n),
	.valid_data_oe_n(valid_data_oe_n));

// [rscp_host_model.sv]
/* host side of the serial command link.
 * assumes a 320 ns link clock that stands still between frames. */
`timescale 1ns/1ns
module rscp_host_model (
	output logic serial_clk,
	output logic port_select_n,
	output logic serial_cmd_in,
	input wire logic serial_status_out
);
	initial begin
		serial_clk = 1'b0;
		port_select_n = 1'b1;
		serial_cmd_in = 1'b0;
	end
	task automatic xfer(input int nb, input logic [23:0] w,
		output logic [23:0] rx);
		rx = 24'h0;
		#7;
		port_select_n = 1'b0;
		#160;
		for (int n = 0; n < nb; n++) begin
			serial_cmd_in = w[23 - n];
			#160;
			serial_clk = 1'b1;
			rx[23 - n] = serial_status_out;
			#160;
			serial_clk = 1'b0;
		end
		#160;
		port_select_n = 1'b1;
		serial_cmd_in = ~serial_cmd_in;
		#400;
	endtask : xfer
endmodule : rscp_host_model

// [testbench.sv]
/* testbench for rscp_port: axi tasks and serial host frames.
 * assumes rscp_pkg, rscp_host_model and the bound checker. */
`timescale 1ns/1ns
module testbench import rscp_pkg::*; ;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, serial_clk;
	logic port_select_n, serial_cmd_in, serial_status_out;
	logic serial_status_oe_n, host_attention_n, ext_event_in_n;
	logic valid_data_flag, valid_data_oe_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] st;
	logic [23:0] rx;
	int error_cnt, total_checks, cyc;
	logic [15:0] por_v [8] = '{CFG_POR, PWR_POR, FREQ_POR, RATE_POR,
		RXC_POR, FIFO_POR, DUTY_POR, TXC_POR};
	logic [15:0] new_v [8] = '{16'h80c7, 16'h82ff, 16'ha345, 16'hc647,
		16'h94a5, 16'hca12, 16'hc8ff, 16'h9870};
	logic [11:0] fq [4] = '{12'h060, 12'h05f, 12'hf3f, 12'hf40};
	logic [11:0] fx [4] = '{12'h060, 12'h060, 12'hf3f, 12'hf3f};
	rscp_port #(.POR_CYCLES(400)) rscp_port_inst (.*);
	rscp_host_model rscp_host_model_inst (.serial_clk(serial_clk),
		.port_select_n(port_select_n), .serial_cmd_in(serial_cmd_in),
		.serial_status_out(serial_status_out));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ----
	// tasks
	// ----
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t timeout", $time);
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read
	task automatic chk_regs(input logic [15:0] v [8]);
		for (int i = 0; i < 8; i++) begin
			axi_read(8'h10 + 8'(4 * i));
			chk(rd & ((i == 2) ? 32'hfff : 32'hffff),
				{16'h0, v[i]} & ((i == 2) ? 32'hfff : 32'hffff));
		end
	endtask : chk_regs
	task automatic cmd(input logic [15:0] c);
		rscp_host_model_inst.xfer(24, {c, 8'h00}, rx);
	endtask : cmd
	task automatic stat();
		rscp_host_model_inst.xfer(24, 24'h0, rx);
		st = rx[22:7];
	endtask : stat
	task automatic irq(input logic e);
		repeat (4) @(posedge aclk);
		chk(32'(host_attention_n), 32'(e));
	endtask : irq
	task automatic pulse();
		ext_event_in_n <= 1'b0;
		repeat (4) @(posedge aclk);
		ext_event_in_n <= 1'b1;
	endtask : pulse
	// ----
	// tests
	// ----
	initial begin
		{error_cnt, total_checks, cyc} = '0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		ext_event_in_n = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cmd(16'ha123);
		chk({host_attention_n, serial_status_oe_n}, 32'h1);
		chk_regs(por_v);
		axi_read(8'h40);
		chk({rd[29:0], rs}, 32'(RESP_ERR));
		axi_write(A_CFG, 32'h0);
		chk(32'(rs), 32'(RESP_ERR));
		$display("test reset done");
		// host defers commands until the power-on timeout is over
		repeat (400) @(posedge aclk);
		stat();
		chk(32'(st & 16'hff00), 32'h2000);
		irq(1'b1);
		for (int i = 0; i < 8; i++)
			cmd(new_v[i]);
		chk_regs(new_v);
		chk(32'(valid_data_oe_n), 32'h0);
		axi_write(A_CTRL, 32'h1);
		chk(32'(valid_data_flag), 32'h1);
		$display("test commands done");
		foreach (fq[i]) begin
			cmd({4'ha, fq[i]});
			axi_read(A_FREQ);
			chk(rd & 32'hfff, 32'(fx[i]));
		end
		rscp_host_model_inst.xfer(7, 24'hffffff, rx);
		cmd(16'ha234);
		axi_read(A_FREQ);
		chk(rd & 32'hfff, 32'h234);
		$display("test frequency done");
		axi_write(A_EVENT, 32'hf);
		irq(1'b0);
		stat();
		chk(32'(st & 16'h8d00), 32'h8d00);
		irq(1'b1);
		pulse();
		irq(1'b1);
		cmd(16'h9080);
		chk(32'(valid_data_oe_n), 32'h1);
		pulse();
		irq(1'b0);
		stat();
		chk(32'(st & 16'h0200), 32'h0200);
		cmd(16'hb8a5);
		axi_read(A_TXB);
		chk(rd, 32'h1a5);
		cmd(16'h8040);
		axi_write(A_EVENT, 32'h3);
		irq(1'b1);
		$display("test events done");
		axi_write(A_RXPUSH, 32'h3c);
		irq(1'b0);
		rscp_host_model_inst.xfer(24, 24'hb00000, rx);
		chk(32'(rx[15:8]), 32'h3c);
		stat();
		chk(32'(st & 16'h5000), 32'h4000);
		repeat (17) axi_write(A_RXPUSH, 32'h11);
		stat();
		chk(32'(st & 16'h1000), 32'h1000);
		cmd(16'h8000);
		axi_write(A_RXPUSH, 32'h22);
		irq(1'b1);
		$display("test fifo done");
		stop_test();
	end
endmodule : testbench
